// *** core/vdt_defines.vh ***
/*
 register numbers, field positions, reset values and timing counts for the
 vlan / priority table access block.
 assumes a plain register port where the register number is the address.
*/
// What this block does
// - vlan entry bit 13 holds port 0 membership, like port 2.
// - vlan entry bit 12 holds port 0 untag control, like port 2.
// - non-member port drops matching frames unless admit-non-member; excluded from broadcast.
// - untag set on hybrid egress port strips tag of matching frames.
// - vlan entry bits 11:0 hold the vlan id, reset zero.
// - vlan id zero is a null vlan and disables the entry.
// - vlan command status bit 0 is a read-only self-clearing pending flag.
// - a priority table indexed by received tos/cs gives a receive priority.
// - a write to the table command register launches one table access unless one is already pending.
// - command bit 7 picks direction: one read, zero write; resets zero.
// - command bits 5:0 pick the entry; bits 6 and 31:8 read zero.
// - a read keeps pending set until the entry is fetched.
// - a write uses preloaded write data; pending stays until entry updated.
// - write data bits 2:0 hold priority to store, read-write, reset zero.
// - read data bits 2:0 return priority from the last completed read.
// - table contents undefined after reset; software initialises every entry.
`ifndef VDT_DEFINES_VH
`define VDT_DEFINES_VH
// ---------------------------------------------------------------
// register numbers
// ---------------------------------------------------------------
`define VDT_REG_VLAN_ENTRY 16'h1800
`define VDT_REG_VLAN_STS 16'h1810
`define VDT_REG_CMD 16'h1811
`define VDT_REG_WR_DATA 16'h1812
`define VDT_REG_RD_DATA 16'h1813
`define VDT_REG_TBL_STS 16'h1814
`define VDT_REG_VLAN_GO 16'h1801
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define VDT_VE_MEMBER0 13
`define VDT_VE_UNTAG0 12
`define VDT_VE_VID_HI 11
`define VDT_CMD_DIR 7
`define VDT_CMD_IDX_HI 5
`define VDT_PRIO_HI 2
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define VDT_VID_RST 12'h000
`define VDT_VID_NULL 12'h000
`define VDT_CMD_RST 8'h00
`define VDT_PRIO_RST 3'h0
`define VDT_ACCESS_CYCLES 4'h2
`endif

// *** core/vdt_prio_table.v ***
/*
 64-entry receive priority memory with one access port for commands and one
 read port for the forwarding engine.
 assumes the caller serialises command accesses.
*/
`timescale 1ns/10ps
`include "vdt_defines.vh"
module vdt_prio_table #(
   parameter AW = 6,
   parameter DW = 3
) (
   // clock
   input wire clk,
   // command port
   input wire we,
   input wire re,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] wdata,
   output reg [DW-1:0] rdata,
   // lookup port
   input wire [AW-1:0] look_idx,
   output wire [DW-1:0] look_prio
);
   // no reset: contents stay undefined until software fills them
   reg [DW-1:0] mem [0:(1<<AW)-1];
   // synchronous access, one cycle
   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (re) begin
         rdata <= mem[addr];
      end
   end
   assign look_prio = mem[look_idx];
endmodule

// *** core/vdt_vlan_filter.v ***
/*
 port 0 view of one vlan entry: ingress admit and egress untag decisions.
 assumes frame vid, admit-non-member and hybrid type come from the engine.
*/
`timescale 1ns/10ps
`include "vdt_defines.vh"
module vdt_vlan_filter (
   // entry
   input wire [13:0] entry,
   // frame and port context
   input wire [11:0] frame_vid,
   input wire admit_non_member_control,
   input wire hybrid_port,
   // decisions
   output wire match,
   output wire drop,
   output wire in_bcast,
   output wire strip_tag
);
   // null vid never matches, so a zeroed entry is disabled
   assign match = (entry[`VDT_VE_VID_HI:0] != `VDT_VID_NULL) && (frame_vid == entry[`VDT_VE_VID_HI:0]);
   assign drop = match && !entry[`VDT_VE_MEMBER0] && !admit_non_member_control;
   assign in_bcast = match && entry[`VDT_VE_MEMBER0];
   assign strip_tag = match && entry[`VDT_VE_UNTAG0] && hybrid_port;
endmodule

// *** core/vdt_top.v ***
/*
 register access for the port 0 vlan entry bits, vlan command status and the
 priority mapping table.
 assumes one clock, a plain register port, and engine inputs on that clock.
*/
`timescale 1ns/10ps
`include "vdt_defines.vh"
module vdt_top (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // register port
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // engine side
   input wire [11:0] frame_vid,
   input wire admit_non_member_control,
   input wire hybrid_port,
   input wire [5:0] look_idx,
   output reg [2:0] look_prio,
   output reg vlan_drop,
   output reg vlan_in_bcast,
   output reg vlan_strip_tag
);
   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   reg rst_s1_r;
   reg rst_s2_r;
   wire rst_n = rst_s2_r;
   // two stages so the release is clean on ref_clk
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   localparam ST_IDLE = 2'd0;
   localparam ST_BUSY = 2'd1;
   localparam ST_DONE = 2'd2;
   reg [13:0] vlan_entry_r;
   reg vlan_pend_r;
   reg [3:0] vlan_cnt_r;
   reg [7:0] cmd_r;
   reg [2:0] wr_data_r;
   reg [2:0] rd_data_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [3:0] cnt_r;
   wire [2:0] mem_rdata;
   wire [2:0] mem_look;
   wire f_match;
   wire f_drop;
   wire f_bcast;
   wire f_strip;
   wire tbl_pend = (state_r != ST_IDLE);
   wire wr_cmd = reg_wr && (reg_addr == `VDT_REG_CMD);
   // commands during pending are dropped to keep the table access atomic
   wire launch = wr_cmd && !tbl_pend;
   wire is_read = cmd_r[`VDT_CMD_DIR];
   wire mem_we = (state_r == ST_BUSY) && (cnt_r == 4'h1) && !is_read;
   wire mem_re = (state_r == ST_BUSY) && (cnt_r == 4'h1) && is_read;

   // ---------------------------------------------------------------
   // table and filter
   // ---------------------------------------------------------------
   vdt_prio_table #(
      .AW(6),
      .DW(3)
   ) u_table (
      .clk(ref_clk),
      .we(mem_we),
      .re(mem_re),
      .addr(cmd_r[`VDT_CMD_IDX_HI:0]),
      .wdata(wr_data_r),
      .rdata(mem_rdata),
      .look_idx(look_idx),
      .look_prio(mem_look)
   );

   vdt_vlan_filter u_filter (
      .entry(vlan_entry_r),
      .frame_vid(frame_vid),
      .admit_non_member_control(admit_non_member_control),
      .hybrid_port(hybrid_port),
      .match(f_match),
      .drop(f_drop),
      .in_bcast(f_bcast),
      .strip_tag(f_strip)
   );

   // ---------------------------------------------------------------
   // table command sequencer
   // ---------------------------------------------------------------
   // next state
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (launch) begin
               state_nxt = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (cnt_r == 4'h1) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // sequencer registers; read data captured in done
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         cmd_r <= `VDT_CMD_RST;
         rd_data_r <= `VDT_PRIO_RST;
      end else begin
         state_r <= state_nxt;
         if (launch) begin
            cmd_r <= {reg_wdata[`VDT_CMD_DIR], 1'b0, reg_wdata[`VDT_CMD_IDX_HI:0]};
            cnt_r <= `VDT_ACCESS_CYCLES;
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
         if ((state_r == ST_DONE) && is_read) begin
            rd_data_r <= mem_rdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   // vlan entry, write data, and a vlan access pending flag
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         vlan_entry_r <= {2'b00, `VDT_VID_RST};
         wr_data_r <= `VDT_PRIO_RST;
         vlan_pend_r <= 1'b0;
         vlan_cnt_r <= 4'h0;
      end else begin
         if (reg_wr && (reg_addr == `VDT_REG_VLAN_ENTRY)) begin
            vlan_entry_r <= reg_wdata[13:0];
         end
         if (reg_wr && (reg_addr == `VDT_REG_WR_DATA)) begin
            wr_data_r <= reg_wdata[`VDT_PRIO_HI:0];
         end
         // a vlan go write marks a command in progress for a fixed time
         if (reg_wr && (reg_addr == `VDT_REG_VLAN_GO) && !vlan_pend_r) begin
            vlan_pend_r <= 1'b1;
            vlan_cnt_r <= `VDT_ACCESS_CYCLES;
         end else if (vlan_cnt_r > 4'h1) begin
            vlan_cnt_r <= vlan_cnt_r - 4'h1;
         end else begin
            vlan_cnt_r <= 4'h0;
            vlan_pend_r <= 1'b0;
         end
      end
   end

   // read decode, data the cycle after the strobe
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         if (reg_addr == `VDT_REG_VLAN_ENTRY) begin
            reg_rdata <= {18'h00000, vlan_entry_r};
         end else if (reg_addr == `VDT_REG_VLAN_STS) begin
            reg_rdata <= {31'h00000000, vlan_pend_r};
         end else if (reg_addr == `VDT_REG_CMD) begin
            reg_rdata <= {24'h000000, cmd_r};
         end else if (reg_addr == `VDT_REG_WR_DATA) begin
            reg_rdata <= {29'h00000000, wr_data_r};
         end else if (reg_addr == `VDT_REG_RD_DATA) begin
            reg_rdata <= {29'h00000000, rd_data_r};
         end else if (reg_addr == `VDT_REG_TBL_STS) begin
            reg_rdata <= {31'h00000000, tbl_pend};
         end else begin
            reg_rdata <= 32'h00000000;
         end
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ---------------------------------------------------------------
   // engine outputs, registered
   // ---------------------------------------------------------------
   // one cycle of latency keeps every output on a flop
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         look_prio <= 3'h0;
         vlan_drop <= 1'b0;
         vlan_in_bcast <= 1'b0;
         vlan_strip_tag <= 1'b0;
      end else begin
         look_prio <= mem_look;
         vlan_drop <= f_drop;
         vlan_in_bcast <= f_bcast && f_match;
         vlan_strip_tag <= f_strip;
      end
   end
endmodule

// *** bench/vdt_properties.sv ***
/*
 port relations of the vlan / priority table access block.
 assumes it is bound to vdt_top and sees its ports only.
*/
`timescale 1ns/10ps
module vdt_properties (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // register port
   input wire [15:0] reg_addr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // engine side
   input wire [11:0] frame_vid,
   input wire admit_non_member_control,
   input wire hybrid_port,
   input wire vlan_drop,
   input wire vlan_in_bcast,
   input wire vlan_strip_tag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // a read strobe aimed at one register number
   sequence s_rd(logic [15:0] a);
      reg_rd && reg_addr == a;
   endsequence
   // read data must not linger, software may sample it late
   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not zero");
   a_vsts_resv_zero: assert property (s_rd(16'h1810) |=> reg_rdata[31:1] == 0) else $error("vsts");
   a_cmd_resv_zero: assert property (s_rd(16'h1811) |=> !reg_rdata[6] && reg_rdata[31:8] == 0) else $error("cmd");
   a_wdat_resv_zero: assert property (s_rd(16'h1812) |=> reg_rdata[31:3] == 0) else $error("wdat");
   a_rdat_resv_zero: assert property (s_rd(16'h1813) |=> reg_rdata[31:3] == 0) else $error("rdat");
   a_pend_resv_zero: assert property (s_rd(16'h1814) |=> reg_rdata[31:1] == 0) else $error("pend");
   a_null_vid_quiet: assert property (frame_vid == 0 |=> !(vlan_drop || vlan_in_bcast || vlan_strip_tag))
      else $error("null vid active");
   a_admit_no_drop: assert property (admit_non_member_control |=> !vlan_drop) else $error("drop on admit");
   a_drop_bcast_excl: assert property (!(vlan_drop && vlan_in_bcast)) else $error("drop and bcast");
   a_strip_hybrid: assert property (!hybrid_port |=> !vlan_strip_tag) else $error("strip non hybrid");
endmodule
bind vdt_top vdt_properties vdt_properties_inst (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_vid(frame_vid),
   .admit_non_member_control(admit_non_member_control), .hybrid_port(hybrid_port),
   .vlan_drop(vlan_drop), .vlan_in_bcast(vlan_in_bcast), .vlan_strip_tag(vlan_strip_tag));

// *** bench/test_vlan_diffserv_table_access.sv ***
/*
 self-checking bench for vdt_top.
 assumes register numbers as addresses and a 3 cycle table pending window.
*/
`timescale 1ns/10ps
module test_vlan_diffserv_table_access;
   reg ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, admit_non_member_control = 0, hybrid_port = 0;
   reg [15:0] reg_addr = 0;
   reg [31:0] reg_wdata = 0, v;
   reg [11:0] frame_vid = 0;
   reg [5:0] look_idx = 0;
   wire [31:0] reg_rdata;
   wire [2:0] look_prio;
   wire vlan_drop, vlan_in_bcast, vlan_strip_tag;
   integer miscompares = 0, check_count = 0, i, n, ones;
   always #2.5 ref_clk = ~ref_clk;
   vdt_top vdt_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_vid(frame_vid),
      .admit_non_member_control(admit_non_member_control), .hybrid_port(hybrid_port),
      .look_idx(look_idx), .look_prio(look_prio), .vlan_drop(vlan_drop),
      .vlan_in_bcast(vlan_in_bcast), .vlan_strip_tag(vlan_strip_tag));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task finish_test;
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input [31:0] s, input [31:0] e);
      check_count = check_count + 1;
      if (s !== e) begin
         miscompares = miscompares + 1;
         $display("ERROR %0s exp %h seen %h", nm, e, s);
      end
   endtask
   // entry priority pattern, mixes both index halves so neighbours differ except entries 31 and 32
   function [31:0] pr(input integer k);
      pr = {29'h0, k[2:0] ^ k[5:3]};
   endfunction
   task wr(input [15:0] a, input [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 0;
   endtask
   task rdchk(input [15:0] a, input [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 0;
      #1 chk($sformatf("reg %h", a), reg_rdata, e);
   endtask
   // command write, optional second write while pending, then status read every cycle
   task cmd(input [31:0] c, input [31:0] c2, input dbl);
      ones = 0;
      @(posedge ref_clk);
      reg_wr <= 1;
      reg_addr <= 16'h1811;
      reg_wdata <= c;
      if (dbl) begin
         @(posedge ref_clk);
         reg_wdata <= c2;
      end
      @(posedge ref_clk);
      reg_wr <= 0;
      reg_rd <= 1;
      reg_addr <= 16'h1814;
      for (n = 0; n < 20; n = n + 1) begin
         @(posedge ref_clk);
         #1;
         if (reg_rdata[0] !== 1'b1)
            n = 99;
         else
            ones = ones + 1;
      end
      if (n == 20) begin
         miscompares = miscompares + 1;
         finish_test;
      end
      @(posedge ref_clk);
      reg_rd <= 0;
      chk("pending cycles", ones, dbl ? 2 : 3);
   endtask
   task eng(input [11:0] vid, input adm, input hyb, input [2:0] e);
      @(posedge ref_clk);
      frame_vid <= vid;
      admit_non_member_control <= adm;
      hybrid_port <= hyb;
      @(posedge ref_clk);
      #1 chk("drop bcast strip", {vlan_drop, vlan_in_bcast, vlan_strip_tag}, e);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset_values;
      rdchk(16'h1800, 0);
      rdchk(16'h1810, 0);
      rdchk(16'h1811, 0);
      rdchk(16'h1812, 0);
      rdchk(16'h1813, 0);
      rdchk(16'h1814, 0);
      rdchk(16'h1815, 0);
   endtask
   task t_vlan_entry;
      wr(16'h1800, 32'hffffffff);
      rdchk(16'h1800, 32'h3fff);
      // traffic entries use ordinary vids, then the null vid, which must stay quiet
      wr(16'h1800, 32'h3123);
      eng(12'h123, 0, 1, 3'b011);
      eng(12'h123, 0, 0, 3'b010);
      eng(12'h124, 0, 1, 3'b000);
      wr(16'h1800, 32'h0123);
      eng(12'h123, 0, 1, 3'b100);
      eng(12'h123, 1, 1, 3'b000);
      wr(16'h1800, 32'h3000);
      eng(12'h000, 0, 1, 3'b000);
      // vlan command start, status seen in the very next cycle
      @(posedge ref_clk);
      reg_wr <= 1;
      reg_addr <= 16'h1801;
      @(posedge ref_clk);
      reg_wr <= 0;
      reg_rd <= 1;
      reg_addr <= 16'h1810;
      @(posedge ref_clk);
      reg_rd <= 0;
      #1 chk("vlan pending", reg_rdata, 1);
      repeat (10) @(posedge ref_clk);
      rdchk(16'h1810, 0);
   endtask
   task t_table;
      // every entry is filled first, since the table wakes up undefined
      for (i = 0; i < 64; i = i + 1) begin
         wr(16'h1812, pr(i));
         cmd(i, 0, 0);
      end
      for (i = 0; i < 64; i = i + 1) begin
         cmd(32'h80 | i, 0, 0);
         rdchk(16'h1813, pr(i));
         @(posedge ref_clk);
         look_idx <= i;
         @(posedge ref_clk);
         #1 chk("look_prio", look_prio, pr(i));
      end
      cmd(32'hffffffff, 0, 0);
      rdchk(16'h1811, 32'hbf);
      rdchk(16'h1813, pr(63));
      wr(16'h1812, 32'hffffffff);
      rdchk(16'h1812, 32'h7);
      // second command while busy must not overwrite entry 9
      cmd(32'h85, 32'h09, 1);
      rdchk(16'h1811, 32'h85);
      rdchk(16'h1813, pr(5));
      cmd(32'h89, 0, 0);
      rdchk(16'h1813, pr(9));
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_b <= 1;
      repeat (3) @(posedge ref_clk);
      t_reset_values;
      t_vlan_entry;
      t_table;
      finish_test;
   end
endmodule
